// ===== include/ldm_defines.svh
`ifndef LDM_DEFINES_SVH
`define LDM_DEFINES_SVH

// Timing
`define LDM_CLK_NS 4
`define LDM_OL_TIME_NS 10000
`define LDM_OL_CYC ((`LDM_OL_TIME_NS + `LDM_CLK_NS - 1) / `LDM_CLK_NS)
`define LDM_RES_NS 400
`define LDM_TICK_CYC (`LDM_RES_NS / `LDM_CLK_NS)
`define LDM_P125_US 8000
`define LDM_P125_TICKS (`LDM_P125_US * 1000 / `LDM_RES_NS)

// Duty arithmetic, Q16
`define LDM_Q16_ONE 17'h1_0000
`define LDM_LOG_ALPHA 17'h0_F274
`define LDM_LVL_MAX 7'h7F

// Register indices
`define LDM_REG_HOST_CFG 3'h0
`define LDM_REG_READBACK 3'h1
`define LDM_REG_FAULT 3'h2
`define LDM_REG_LEVEL 3'h3
`define LDM_REG_CHAN_SEL 3'h4
`define LDM_REG_OPTIONS 3'h5

// Field positions
`define LDM_F_MODE 15
`define LDM_F_ACTIVATE 12
`define LDM_F_LOW_RATE 7
`define LDM_F_LINEAR 1
`define LDM_F_HIGH_RATE 0

// Reset values
`define LDM_RST16 16'h0000
`define LDM_RST8 8'h00

`endif

// ===== include/ldm_pkg.sv
package ldm_pkg;
	typedef logic [11:0] ldm_chan_t;
	typedef logic [14:0] ldm_ticks_t;
	typedef logic [16:0] ldm_q16_t;
	typedef enum logic {ldm_calc_idle, ldm_calc_step} ldm_calc_st_t;

	function automatic ldm_q16_t ldm_mul_q16(input ldm_q16_t a, input ldm_q16_t b);
		logic [33:0] p;
		p = a * b;
		return p[32:16];
	endfunction
endpackage

// ===== include/ldm_pwm_if.sv
`timescale 1ns/100ps
interface ldm_pwm_if;
	logic [6:0] level;
	logic linear;
	logic high_rate;
	logic low_rate;
	logic run;
	logic wave;
	modport core (output level, linear, high_rate, low_rate, run, input wave);
	modport gen (input level, linear, high_rate, low_rate, run, output wave);
endinterface

// ===== logic/ldm_pwm_gen.sv
`timescale 1ns/100ps
`include "ldm_defines.svh"
module ldm_pwm_gen #(parameter int P125_TICKS = `LDM_P125_TICKS)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Settings and waveform
	ldm_pwm_if.gen pif
);
	localparam ldm_pkg::ldm_ticks_t PER125 = 15'(P125_TICKS);
	localparam logic [6:0] TICK_LAST = 7'(`LDM_TICK_CYC - 1);

	logic [6:0] tick_r, tick_nxt;
	ldm_pkg::ldm_ticks_t cnt_r, cnt_nxt, len_r, len_nxt, on_r, on_nxt, per_sel;
	ldm_pkg::ldm_q16_t frac_r, frac_nxt, work_r, work_nxt, scaled;
	logic [6:0] steps_r, steps_nxt;
	logic [7:0] key_r, key_nxt;
	logic wave_r, wave_nxt, restart;
	ldm_pkg::ldm_calc_st_t st_r, st_nxt;

	assign pif.wave = wave_r;

	always_comb
	begin
		per_sel = pif.high_rate ? (PER125 >> 2) : (pif.low_rate ? (PER125 >> 1) : PER125);
		scaled = ldm_pkg::ldm_mul_q16({2'b00, per_sel}, frac_r);
		tick_nxt = (tick_r == TICK_LAST) ? 7'h00 : tick_r + 7'h01;
		restart = !pif.run || ((tick_r == TICK_LAST) && (cnt_r >= len_r - 15'h0001));
		cnt_nxt = cnt_r;
		len_nxt = len_r;
		on_nxt = on_r;
		// Duty is taken only at a period boundary or while stopped, so a change never glitches a cycle
		if (restart)
		begin
			cnt_nxt = '0;
			len_nxt = per_sel;
			on_nxt = scaled[14:0];
		end
		else if (tick_r == TICK_LAST)
			cnt_nxt = cnt_r + 15'h0001;
		if (!pif.run)
			tick_nxt = '0;
		wave_nxt = pif.run && (cnt_r < on_r);
	end

	// Log curve: alpha applied once per cycle, 127 - level times
	always_comb
	begin
		st_nxt = st_r;
		key_nxt = key_r;
		frac_nxt = frac_r;
		work_nxt = work_r;
		steps_nxt = steps_r;
		case (st_r)
			ldm_pkg::ldm_calc_idle:
				if ({pif.linear, pif.level} != key_r)
				begin
					key_nxt = {pif.linear, pif.level};
					if (pif.linear)
						frac_nxt = {({1'b0, pif.level} + 8'h01), 9'h000};
					else
					begin
						work_nxt = `LDM_Q16_ONE;
						steps_nxt = `LDM_LVL_MAX - pif.level;
						st_nxt = ldm_pkg::ldm_calc_step;
					end
				end
			ldm_pkg::ldm_calc_step:
				if (steps_r == 7'h00)
				begin
					frac_nxt = work_r;
					st_nxt = ldm_pkg::ldm_calc_idle;
				end
				else
				begin
					work_nxt = ldm_pkg::ldm_mul_q16(work_r, `LDM_LOG_ALPHA);
					steps_nxt = steps_r - 7'h01;
				end
			default:
				st_nxt = ldm_pkg::ldm_calc_idle;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_r <= '0;
			cnt_r <= '0;
			len_r <= '0;
			on_r <= '0;
			wave_r <= 1'b0;
			st_r <= ldm_pkg::ldm_calc_idle;
			key_r <= `LDM_RST8;
			frac_r <= {9'h000, 8'h80};
			work_r <= '0;
			steps_r <= '0;
		end
		else
		begin
			tick_r <= tick_nxt;
			cnt_r <= cnt_nxt;
			len_r <= len_nxt;
			on_r <= on_nxt;
			wave_r <= wave_nxt;
			st_r <= st_nxt;
			key_r <= key_nxt;
			frac_r <= frac_nxt;
			work_r <= work_nxt;
			steps_r <= steps_nxt;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	fast_rate_a: assert property ((restart && pif.high_rate) |=> len_r == (PER125 >> 2))
		else $error("High rate did not give the quarter period");
	mid_rate_a: assert property ((restart && !pif.high_rate && pif.low_rate)
		|=> len_r == (PER125 >> 1))
		else $error("Low rate select did not give the half period");
	log_full_a: assert property ((st_r == ldm_pkg::ldm_calc_idle && key_r == 8'h7F)
		|-> frac_r == `LDM_Q16_ONE)
		else $error("Top log level is not full duty");
	linear_duty_a: assert property ((st_r == ldm_pkg::ldm_calc_idle && key_r[7])
		|-> frac_r == {({1'b0, key_r[6:0]} + 8'h01), 9'h000})
		else $error("Linear duty not proportional to level");
	stop_wave_a: assert property (!pif.run |=> !pif.wave)
		else $error("Waveform runs while dimming is stopped");
	log_calc_c: cover property (st_r == ldm_pkg::ldm_calc_step ##1 st_r == ldm_pkg::ldm_calc_idle);
	wave_rise_c: cover property ($rose(wave_r));
endmodule

// ===== logic/ldm_core.sv
`timescale 1ns/100ps
`include "ldm_defines.svh"
// Function
// - The readback register returns the host on bits in host mode, else the chosen stand-alone bits, with mode, diagnostic and activate bits on top.
// - A channel's fault bit sets only after open load has lasted longer than 10 us.
// - Reading the fault register clears it once the value has been returned.
// - The generator offers 128 dimming steps from one shared 7-bit level.
// - The log curve gives duty 100 * 0.9471^(127 - level) percent on a 400 ns grid.
// - With the high rate clear, the low rate bit picks 250 Hz when set and 125 Hz when clear.
// - With the high rate set, dimming runs at 500 Hz whatever the low rate bit.
// - Each channel's dim enable bit applies the waveform to that channel or leaves it undimmed.
// - The linear select bit chooses the log curve at 0 and a linear map at 1.
// - The activate bit runs the generator; clearing it stops dimming but keeps the enables.
// - Host mode holds only while the mode flag is set and the logic supply is present.
// - A host channel bit of 0 turns the output off and 1 turns it on.
module ldm_core #(parameter int P125_TICKS = `LDM_P125_TICKS)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [2:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	// Device pins
	input wire logic vdd_present,
	input wire logic standalone_b_sel,
	input wire logic [11:0] open_load_pin,
	// Stand-alone bank
	input wire logic [11:0] standalone_config_a,
	input wire logic [11:0] standalone_config_b,
	// Channel drive
	output logic [11:0] channel_output
);
	localparam logic [11:0] OL_CYC = 12'(`LDM_OL_CYC);

	ldm_pwm_if pif ();

	logic [13:0] sync1_r, sync2_r;
	logic vdd_s, bsel_s;
	ldm_pkg::ldm_chan_t ol_s, sa_bits, on_bits, fault_set;
	logic host_mode;
	logic [15:0] rb_val;

	logic [15:0] host_cfg_r, host_cfg_nxt, rdata_r, rdata_nxt;
	logic [7:0] lvl_r, lvl_nxt;
	logic [1:0] opt_r, opt_nxt;
	ldm_pkg::ldm_chan_t en_r, en_nxt, fault_r, fault_nxt, out_r, out_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [11:0] ol_cnt_r [12];
	logic [11:0] ol_cnt_nxt [12];

	assign vdd_s = sync2_r[13];
	assign bsel_s = sync2_r[12];
	assign ol_s = sync2_r[11:0];
	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign channel_output = out_r;

	assign pif.level = lvl_r[6:0];
	assign pif.low_rate = lvl_r[`LDM_F_LOW_RATE];
	assign pif.linear = opt_r[`LDM_F_LINEAR];
	assign pif.high_rate = opt_r[`LDM_F_HIGH_RATE];
	assign pif.run = host_cfg_r[`LDM_F_ACTIVATE];

	ldm_pwm_gen #(.P125_TICKS(P125_TICKS)) u_gen
	(
		.mclk(mclk),
		.rst_n(rst_n),
		.pif(pif)
	);

	// Channel selection and readback
	always_comb
	begin
		host_mode = host_cfg_r[`LDM_F_MODE] && vdd_s;
		sa_bits = bsel_s ? standalone_config_b : standalone_config_a;
		on_bits = host_mode ? host_cfg_r[11:0] : sa_bits;
		rb_val = {host_cfg_r[15:12], on_bits};
		for (int k = 0; k < 12; k++)
			out_nxt[k] = on_bits[k] && (!(en_r[k] && pif.run) || pif.wave);
	end

	// Open-load filters
	always_comb
	begin
		for (int k = 0; k < 12; k++)
		begin
			ol_cnt_nxt[k] = '0;
			if (ol_s[k])
				ol_cnt_nxt[k] = (ol_cnt_r[k] < OL_CYC) ? ol_cnt_r[k] + 12'h001 : ol_cnt_r[k];
			fault_set[k] = ol_s[k] && (ol_cnt_r[k] == OL_CYC);
		end
	end

	// Register file
	always_comb
	begin
		host_cfg_nxt = host_cfg_r;
		lvl_nxt = lvl_r;
		opt_nxt = opt_r;
		en_nxt = en_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = 1'b0;
		fault_nxt = fault_r;
		if (reg_rd)
		begin
			rvalid_nxt = 1'b1;
			case (reg_addr)
				`LDM_REG_READBACK: rdata_nxt = rb_val;
				`LDM_REG_FAULT:
				begin
					rdata_nxt = {4'h0, fault_r};
					fault_nxt = '0;
				end
				default: rdata_nxt = `LDM_RST16;
			endcase
		end
		// A fault arriving on the read cycle survives to the next read
		fault_nxt = fault_nxt | fault_set;
		if (reg_wr)
		begin
			case (reg_addr)
				`LDM_REG_HOST_CFG: host_cfg_nxt = reg_wdata;
				`LDM_REG_LEVEL: lvl_nxt = reg_wdata[7:0];
				`LDM_REG_CHAN_SEL: en_nxt = reg_wdata[11:0];
				`LDM_REG_OPTIONS: opt_nxt = reg_wdata[1:0];
				default: ;
			endcase
		end
		// Losing the logic supply drops back to stand-alone until the host sets the mode flag again
		if (!vdd_s)
			host_cfg_nxt[`LDM_F_MODE] = 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
			host_cfg_r <= `LDM_RST16;
			lvl_r <= `LDM_RST8;
			opt_r <= '0;
			en_r <= '0;
			fault_r <= '0;
			out_r <= '0;
			rdata_r <= `LDM_RST16;
			rvalid_r <= 1'b0;
			for (int k = 0; k < 12; k++)
				ol_cnt_r[k] <= '0;
		end
		else
		begin
			sync1_r <= {vdd_present, standalone_b_sel, open_load_pin};
			sync2_r <= sync1_r;
			host_cfg_r <= host_cfg_nxt;
			lvl_r <= lvl_nxt;
			opt_r <= opt_nxt;
			en_r <= en_nxt;
			fault_r <= fault_nxt;
			out_r <= out_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
			for (int k = 0; k < 12; k++)
				ol_cnt_r[k] <= ol_cnt_nxt[k];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	readback_bits_a: assert property ((reg_rd && reg_addr == `LDM_REG_READBACK)
		|=> reg_rdata[11:0] == $past(host_mode ? host_cfg_r[11:0] : sa_bits))
		else $error("Readback channel bits do not follow the mode");
	readback_top_a: assert property ((reg_rd && reg_addr == `LDM_REG_READBACK)
		|=> reg_rdata[15:12] == $past(host_cfg_r[15:12]) && reg_rvalid)
		else $error("Readback upper bits wrong");
	host_mode_a: assert property (!vdd_s |=> !host_cfg_r[`LDM_F_MODE])
		else $error("Host mode kept without logic supply");
	fault_filter_a: assert property ($rose(fault_r[0]) |-> $past(ol_cnt_r[0]) == OL_CYC)
		else $error("Fault set before the open-load filter expired");
	fault_clear_a: assert property ((reg_rd && reg_addr == `LDM_REG_FAULT)
		|=> reg_rdata[11:0] == $past(fault_r) && fault_r == $past(fault_set))
		else $error("Fault register not returned and cleared");
	chan_off_a: assert property ((host_mode && !host_cfg_r[0] && vdd_s)
		|=> !channel_output[0])
		else $error("Channel on while its host bit is clear");
	undimmed_a: assert property ((on_bits[0] && !en_r[0]) |=> channel_output[0])
		else $error("Undimmed channel was gated");
	level_write_a: assert property ((reg_wr && reg_addr == `LDM_REG_LEVEL)
		|=> pif.level == $past(reg_wdata[6:0]))
		else $error("Dimming level not taken");
	fault_seen_c: cover property ($rose(fault_r[0]) ##[1:20] (reg_rd && reg_addr == `LDM_REG_FAULT));
	host_dim_c: cover property (host_mode && en_r[0] && pif.run && $fell(channel_output[0]));
endmodule

// ===== tb/ldm_host_model.sv
`timescale 1ns/100ps
module ldm_host_model
(
	// Clock
	input wire logic mclk,
	// Register bus
	output logic reg_wr,
	output logic reg_rd,
	output logic [2:0] reg_addr,
	output logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid
);
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h7;
		reg_wdata = 16'hFFFF;
	end

	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		// Scrambled after release so a stale value never looks valid
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (reg_rvalid !== 1'b1 && n < 4);
		d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
	endtask
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic vdd_present = 1'b1;
	logic standalone_b_sel = 1'b0;
	logic [11:0] open_load_pin = 12'h000;
	logic [11:0] cfg_a = 12'h000;
	logic [11:0] cfg_b = 12'h000;
	logic [11:0] channel_output;
	logic reg_wr;
	logic reg_rd;
	logic [2:0] reg_addr;
	logic [15:0] reg_wdata;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic steady1;
	logic [15:0] v;
	int err_total = 0;
	int checked = 0;

	ldm_core #(.P125_TICKS(40)) dut (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .vdd_present(vdd_present), .standalone_b_sel(standalone_b_sel),
		.open_load_pin(open_load_pin), .standalone_config_a(cfg_a), .standalone_config_b(cfg_b),
		.channel_output(channel_output));
	ldm_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

	always #2 mclk = ~mclk;

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task complete_run;
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Period and high time of channel 0, from one rising edge to the next
	task automatic measure(output logic [15:0] per, output logic [15:0] hi);
		int n;
		logic p;
		n = 0;
		per = 16'h0000;
		hi = 16'h0000;
		do
		begin
			p = channel_output[0];
			@(posedge mclk);
			n++;
		end
		while (!(p === 1'b0 && channel_output[0] === 1'b1) && n < 20000);
		do
		begin
			hi = hi + {15'h0000, channel_output[0]};
			per++;
			steady1 = steady1 & channel_output[1];
			p = channel_output[0];
			@(posedge mclk);
		end
		while (!(p === 1'b0 && channel_output[0] === 1'b1) && per < 16'h4E20);
	endtask

	// First period may still carry the old settings, so it is discarded
	task automatic expect_wave(input logic [15:0] ep, input logic [15:0] eh);
		logic [15:0] per;
		logic [15:0] hi;
		measure(per, hi);
		steady1 = 1'b1;
		measure(per, hi);
		check("period", per, ep);
		check("high_time", hi, eh);
		check("undimmed_ch1", {15'h0000, steady1}, 16'h0001);
	endtask

	task t_reset;
		host.rd(3'h1, v);
		check("readback_rst", v, 16'h0000);
		host.rd(3'h2, v);
		check("fault_rst", v, 16'h0000);
		host.rd(3'h3, v);
		check("level_wo", v, 16'h0000);
		host.rd(3'h7, v);
		check("unmapped", v, 16'h0000);
		check("out_rst", {4'h0, channel_output}, 16'h0000);
	endtask

	task t_modes;
		cfg_a <= 12'h5A5;
		cfg_b <= 12'h3C3;
		host.wr(3'h0, 16'hEABC);
		host.rd(3'h1, v);
		check("readback_host", v, 16'hEABC);
		check("out_host", {4'h0, channel_output}, 16'h0ABC);
		vdd_present <= 1'b0;
		repeat (6) @(posedge mclk);
		host.rd(3'h1, v);
		check("readback_sa_a", v, 16'h65A5);
		check("out_sa_a", {4'h0, channel_output}, 16'h05A5);
		standalone_b_sel <= 1'b1;
		repeat (6) @(posedge mclk);
		host.rd(3'h1, v);
		check("readback_sa_b", v, 16'h63C3);
		vdd_present <= 1'b1;
		standalone_b_sel <= 1'b0;
	endtask

	task t_fault;
		open_load_pin <= 12'h008;
		repeat (1000) @(posedge mclk);
		open_load_pin <= 12'h000;
		repeat (10) @(posedge mclk);
		host.rd(3'h2, v);
		check("fault_short", v, 16'h0000);
		open_load_pin <= 12'h009;
		repeat (2400) @(posedge mclk);
		host.rd(3'h2, v);
		check("fault_early", v, 16'h0000);
		repeat (200) @(posedge mclk);
		open_load_pin <= 12'h000;
		// Let the release pass the synchroniser, else the held fault sets again
		repeat (4) @(posedge mclk);
		host.rd(3'h2, v);
		check("fault_set", v, 16'h0009);
		host.rd(3'h2, v);
		check("fault_clr", v, 16'h0000);
	endtask

	task t_pwm;
		int ones;
		host.wr(3'h0, 16'h9003);
		host.wr(3'h4, 16'h0001);
		host.wr(3'h5, 16'h0000);
		host.wr(3'h3, 16'h007F);
		repeat (4100) @(posedge mclk);
		ones = 0;
		repeat (400)
		begin
			@(posedge mclk);
			ones += (channel_output[0] === 1'b1) ? 1 : 0;
		end
		check("full_duty", 16'(ones), 16'h0190);
		host.wr(3'h3, 16'h0072);
		expect_wave(16'h0FA0, 16'h076C);
		host.wr(3'h5, 16'h0002);
		host.wr(3'h3, 16'h00BF);
		expect_wave(16'h07D0, 16'h03E8);
		host.wr(3'h5, 16'h0003);
		expect_wave(16'h03E8, 16'h01F4);
		host.wr(3'h0, 16'h8003);
		repeat (10) @(posedge mclk);
		ones = 0;
		repeat (1200)
		begin
			@(posedge mclk);
			ones += (channel_output[0] === 1'b1) ? 1 : 0;
		end
		check("stopped", 16'(ones), 16'h04B0);
		host.wr(3'h0, 16'h9003);
		expect_wave(16'h03E8, 16'h01F4);
	endtask

	initial
	begin
		steady1 = 1'b1;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset;
		t_modes;
		t_fault;
		t_pwm;
		complete_run;
	end

	initial
	begin
		#300000;
		err_total++;
		complete_run;
	end
endmodule
